/* core/fps_bit_timer.sv */
// Bit period tick generator with exact fractional division
`timescale 1ns/100ps

module fps_bit_timer
    import fps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire fps_speed_t speed,
    output logic bit_tick
);

    logic [27:0] acc_reg;
    logic [27:0] acc_next;
    logic tick_reg;
    logic tick_next;
    logic [27:0] sum;

    // Phase accumulator wraps at the clock rate
    always_comb
    begin
        sum = acc_reg + fps_bps(speed);
        tick_next = (sum >= `FPS_CLK_HZ);
        acc_next = tick_next ? sum - `FPS_CLK_HZ : sum;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_reg <= 28'h0000000;
            tick_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            tick_reg <= tick_next;
        end
    end

    assign bit_tick = tick_reg;

endmodule // fps_bit_timer

/* core/fps_buf2.sv */
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps

module fps_buf2
    import fps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire fps_byte_t in_data,
    output logic in_ready,
    output logic out_valid,
    output fps_byte_t out_data,
    input wire logic out_ready
);

    fps_byte_t mem_reg [2];
    fps_byte_t mem_next [2];
    logic wp_reg;
    logic wp_next;
    logic rp_reg;
    logic rp_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic push;
    logic pop;

    // Pointer and count update; ready and valid decoded from the registered count
    always_comb
    begin
        push = in_valid && (cnt_reg != 2'h2);
        pop = out_ready && (cnt_reg != 2'h0);
        mem_next = mem_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        if (push)
        begin
            mem_next[wp_reg] = in_data;
            wp_next = ~wp_reg;
        end
        if (pop)
            rp_next = ~rp_reg;
        cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_reg[0] <= 8'h00;
            mem_reg[1] <= 8'h00;
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            mem_reg <= mem_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem_reg[rp_reg];

endmodule // fps_buf2

/* core/fps_defines.svh */
// Timing constants for the poll scheduler
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// Core clock
`define FPS_CLK_HZ 28'h5F5E100
`define FPS_CLK_PERIOD_NS 10

// Frame overhead characters and bits per character
`define FPS_FRAME_OVH_CHARS 9'h009
`define FPS_CHAR_BITS 4'hB

// Fixed overheads, in nanoseconds
`define FPS_REFRESH_BASE_NS 1200000
`define FPS_REFRESH_SLAVE_NS 1200
`define FPS_HOST_ACCESS_NS 3300000
`define FPS_MSI_UNIT_NS 100000

// Line speeds in bits per second
`define FPS_BPS_9K6 28'h0002580
`define FPS_BPS_19K2 28'h0004B00
`define FPS_BPS_93K75 28'h0016E36
`define FPS_BPS_187K5 28'h002DC6C
`define FPS_BPS_500K 28'h007A120
`define FPS_BPS_1M5 28'h016E360
`define FPS_BPS_3M 28'h02DC6C0
`define FPS_BPS_6M 28'h05B8D80
`define FPS_BPS_12M 28'h0B71B00

// Master turnaround in bit periods
`define FPS_TSDI_LOW 16'h0046
`define FPS_TSDI_500K 16'h0096
`define FPS_TSDI_1M5 16'h00C8
`define FPS_TSDI_3M 16'h00FA
`define FPS_TSDI_6M 16'h01C2
`define FPS_TSDI_12M 16'h0320

`endif

/* core/fps_pkg.sv */
// Types and speed decode for the poll scheduler
`include "fps_defines.svh"

package fps_pkg;

    typedef enum logic [3:0] {
        FPS_SPD_9K6 = 4'h0,
        FPS_SPD_19K2 = 4'h1,
        FPS_SPD_93K75 = 4'h2,
        FPS_SPD_187K5 = 4'h3,
        FPS_SPD_500K = 4'h4,
        FPS_SPD_1M5 = 4'h5,
        FPS_SPD_3M = 4'h6,
        FPS_SPD_6M = 4'h7,
        FPS_SPD_12M = 4'h8
    } fps_speed_t;

    typedef enum logic [7:0] {
        FPS_ST_IDLE = 8'h01,
        FPS_ST_XFER = 8'h02,
        FPS_ST_REQ = 8'h04,
        FPS_ST_WAIT = 8'h08,
        FPS_ST_RESP = 8'h10,
        FPS_ST_TSDI = 8'h20,
        FPS_ST_OVH = 8'h40,
        FPS_ST_HOLD = 8'h80
    } fps_state_t;

    // Per-slave configuration entry
    typedef struct packed {
        logic [7:0] out_bytes;
        logic [7:0] in_bytes;
        logic [7:0] out_base;
        logic [7:0] in_base;
        logic [15:0] max_tsdr;
    } fps_slave_cfg_t;

    // One byte of a frame
    typedef struct packed {
        logic [7:0] data;
    } fps_byte_t;

    // Line speed in bits per second
    function automatic logic [27:0] fps_bps(input fps_speed_t spd);
        unique case (spd)
            FPS_SPD_9K6: fps_bps = `FPS_BPS_9K6;
            FPS_SPD_19K2: fps_bps = `FPS_BPS_19K2;
            FPS_SPD_93K75: fps_bps = `FPS_BPS_93K75;
            FPS_SPD_187K5: fps_bps = `FPS_BPS_187K5;
            FPS_SPD_500K: fps_bps = `FPS_BPS_500K;
            FPS_SPD_1M5: fps_bps = `FPS_BPS_1M5;
            FPS_SPD_3M: fps_bps = `FPS_BPS_3M;
            FPS_SPD_6M: fps_bps = `FPS_BPS_6M;
            FPS_SPD_12M: fps_bps = `FPS_BPS_12M;
            default: fps_bps = `FPS_BPS_9K6;
        endcase
    endfunction

    // Master processing time in bit periods
    function automatic logic [15:0] fps_tsdi(input fps_speed_t spd);
        unique case (spd)
            FPS_SPD_500K: fps_tsdi = `FPS_TSDI_500K;
            FPS_SPD_1M5: fps_tsdi = `FPS_TSDI_1M5;
            FPS_SPD_3M: fps_tsdi = `FPS_TSDI_3M;
            FPS_SPD_6M: fps_tsdi = `FPS_TSDI_6M;
            FPS_SPD_12M: fps_tsdi = `FPS_TSDI_12M;
            default: fps_tsdi = `FPS_TSDI_LOW;
        endcase
    endfunction

endpackage

/* core/fps_poll_sched.sv */
// Cyclic slave polling scheduler with shared host buffer
// What this block does
// - The bus cycle lasts the longer of the minimum interval and the poll round with its overheads.
// - When the interval is longer, buffers are exchanged once per minimum interval.
// - Host writes to the shared buffer reach the internal buffer only at the next transfer point.
// - Host access and the bus cycle are unsynchronised and each tolerates changes by the other.
// - Each slave is polled as request, wait for answer, response unless the wait times out, master turnaround, then the next slave.
// - A request frame lasts output bytes plus 9 characters of 11 bit periods each.
// - One bit period is the reciprocal of the line speed, so all bit delays scale with it.
// - Master processing is 70, 150 or 200 bit periods up to 187.5k, at 500k and at 1.5M.
// - Master processing is 250, 450 or 800 bit periods at 3M, 6M and 12M.
// - Refresh overhead is 1.2 ms plus 1.2 us per configured slave.
`timescale 1ns/100ps

module fps_poll_sched
    import fps_pkg::*;
#(
    parameter int NSLV = 8,
    parameter int BUF_DEPTH = 64,
    parameter int REFRESH_BASE_CYC =
        (`FPS_REFRESH_BASE_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS,
    parameter int HOST_ACCESS_CYC =
        (`FPS_HOST_ACCESS_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS,
    parameter int MSI_UNIT_CYC =
        (`FPS_MSI_UNIT_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic poll_enable,
    input wire fps_speed_t speed,
    input wire logic [15:0] min_poll_interval,
    input wire logic [7:0] slave_count,
    input wire logic [3:0] host_access_count,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_idx,
    input wire fps_slave_cfg_t cfg_data,
    input wire logic host_we,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire logic rx_start,
    input wire logic rx_valid,
    input wire fps_byte_t rx_data,
    output logic rx_ready,
    output fps_state_t poll_state,
    output logic [7:0] poll_slave,
    output logic tx_byte_valid,
    output fps_byte_t tx_byte,
    output logic cycle_start,
    output logic [31:0] bus_cycle_period,
    output logic [NSLV-1:0] slave_timeout
);

    localparam int SW = (NSLV > 1) ? $clog2(NSLV) : 1;
    localparam int AW = $clog2(BUF_DEPTH);
    localparam logic [31:0] REFRESH_SLAVE_CYC = 32'(
        (`FPS_REFRESH_SLAVE_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS);

    fps_state_t st_reg, st_next;
    fps_speed_t spd_reg, spd_next;
    logic [7:0] slv_reg, slv_next;
    logic [7:0] nslv_reg, nslv_next;
    logic [3:0] bit_reg, bit_next;
    logic [8:0] chr_reg, chr_next;
    logic [15:0] tck_reg, tck_next;
    logic [31:0] msi_cnt_reg, msi_cnt_next;
    logic [31:0] msi_tgt_reg, msi_tgt_next;
    logic [31:0] ovh_cnt_reg, ovh_cnt_next;
    logic [31:0] ovh_tgt_reg, ovh_tgt_next;
    logic [31:0] per_reg, per_next;
    logic [31:0] period_reg, period_next;
    logic cyc_reg, cyc_next;
    logic txv_reg, txv_next;
    fps_byte_t txb_reg, txb_next;
    logic [NSLV-1:0] to_reg, to_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] rx_ptr_reg, rx_ptr_next;
    logic sync1_reg, sync2_reg;

    fps_slave_cfg_t cfg_reg [NSLV];
    fps_slave_cfg_t cfg_next [NSLV];
    logic [7:0] sh_out_reg [BUF_DEPTH];
    logic [7:0] sh_out_next [BUF_DEPTH];
    logic [7:0] sh_in_reg [BUF_DEPTH];
    logic [7:0] sh_in_next [BUF_DEPTH];
    logic [7:0] io_out_reg [BUF_DEPTH];
    logic [7:0] io_out_next [BUF_DEPTH];
    logic [7:0] io_in_reg [BUF_DEPTH];
    logic [7:0] io_in_next [BUF_DEPTH];

    fps_slave_cfg_t cur;
    logic bit_tick;
    logic char_end;
    logic [8:0] frame_len;
    logic last_slave;
    logic drain_valid;
    logic drain_ready;
    fps_byte_t drain_data;
    logic [7:0] out_idx;
    logic [7:0] in_idx;

    // Bit period clock follows the latched line speed
    fps_bit_timer u_bit_timer (
        .core_clk(core_clk),
        .rstn(rstn),
        .speed(spd_reg),
        .bit_tick(bit_tick)
    );

    // Receive bytes park here while XFER stalls
    fps_buf2 u_rx_buf (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(rx_valid),
        .in_data(rx_data),
        .in_ready(rx_ready),
        .out_valid(drain_valid),
        .out_data(drain_data),
        .out_ready(drain_ready)
    );

    // Frame start pin passes two flops before use
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= rx_start;
            sync2_reg <= sync1_reg;
        end
    end

    // Current slave and frame decode
    assign cur = cfg_reg[slv_reg[SW-1:0]];
    assign char_end = bit_tick && (bit_reg == `FPS_CHAR_BITS - 4'h1);
    assign frame_len = (st_reg == FPS_ST_REQ) ?
        {1'b0, cur.out_bytes} + `FPS_FRAME_OVH_CHARS :
        {1'b0, cur.in_bytes} + `FPS_FRAME_OVH_CHARS;
    assign last_slave = ({1'b0, slv_reg} + 9'h001 >= {1'b0, nslv_reg});
    assign out_idx = cur.out_base + chr_reg[7:0];
    assign in_idx = cur.in_base + rx_ptr_reg;
    assign drain_ready = (st_reg != FPS_ST_XFER);

    // Poll sequencer and cycle timing
    always_comb
    begin
        st_next = st_reg;
        spd_next = spd_reg;
        slv_next = slv_reg;
        nslv_next = nslv_reg;
        bit_next = bit_reg;
        chr_next = chr_reg;
        tck_next = tck_reg;
        msi_cnt_next = (msi_cnt_reg == 32'hFFFFFFFF) ?
            msi_cnt_reg : msi_cnt_reg + 32'h1;
        msi_tgt_next = msi_tgt_reg;
        ovh_cnt_next = ovh_cnt_reg;
        ovh_tgt_next = ovh_tgt_reg;
        per_next = per_reg + 32'h1;
        period_next = period_reg;
        cyc_next = 1'b0;
        txv_next = 1'b0;
        txb_next = txb_reg;
        to_next = to_reg;
        unique case (st_reg)
            FPS_ST_IDLE:
            begin
                per_next = 32'h0;
                if (poll_enable)
                begin
                    // Config frozen for the run
                    spd_next = speed;
                    nslv_next = slave_count;
                    msi_tgt_next = 32'(min_poll_interval)
                        * 32'(MSI_UNIT_CYC);
                    ovh_tgt_next = 32'(REFRESH_BASE_CYC)
                        + 32'(slave_count) * REFRESH_SLAVE_CYC
                        + 32'(host_access_count) * 32'(HOST_ACCESS_CYC);
                    st_next = FPS_ST_XFER;
                end
            end
            FPS_ST_XFER:
            begin
                // Transfer point opens a cycle
                cyc_next = 1'b1;
                period_next = per_reg + 32'h1;
                per_next = 32'h0;
                msi_cnt_next = 32'h1;
                slv_next = 8'h00;
                bit_next = 4'h0;
                chr_next = 9'h000;
                ovh_cnt_next = 32'h0;
                st_next = (nslv_reg == 8'h00) ? FPS_ST_OVH : FPS_ST_REQ;
            end
            FPS_ST_REQ:
            begin
                if (bit_tick)
                    bit_next = bit_reg + 4'h1;
                if (char_end)
                begin
                    bit_next = 4'h0;
                    chr_next = chr_reg + 9'h001;
                    if (chr_reg < {1'b0, cur.out_bytes})
                    begin
                        txv_next = 1'b1;
                        txb_next = io_out_reg[out_idx[AW-1:0]];
                    end
                    if (chr_reg == frame_len - 9'h001)
                    begin
                        chr_next = 9'h000;
                        tck_next = 16'h0000;
                        st_next = FPS_ST_WAIT;
                    end
                end
            end
            FPS_ST_WAIT:
            begin
                if (sync2_reg)
                begin
                    bit_next = 4'h0;
                    to_next[slv_reg[SW-1:0]] = 1'b0;
                    st_next = FPS_ST_RESP;
                end
                else if (bit_tick)
                begin
                    tck_next = tck_reg + 16'h0001;
                    if (tck_next >= cur.max_tsdr)
                    begin
                        to_next[slv_reg[SW-1:0]] = 1'b1;
                        tck_next = 16'h0000;
                        st_next = FPS_ST_TSDI;
                    end
                end
            end
            FPS_ST_RESP:
            begin
                if (bit_tick)
                    bit_next = bit_reg + 4'h1;
                if (char_end)
                begin
                    bit_next = 4'h0;
                    chr_next = chr_reg + 9'h001;
                    if (chr_reg == frame_len - 9'h001)
                    begin
                        chr_next = 9'h000;
                        tck_next = 16'h0000;
                        st_next = FPS_ST_TSDI;
                    end
                end
            end
            FPS_ST_TSDI:
            begin
                if (bit_tick)
                begin
                    tck_next = tck_reg + 16'h0001;
                    if (tck_next >= fps_tsdi(spd_reg))
                    begin
                        bit_next = 4'h0;
                        slv_next = slv_reg + 8'h01;
                        st_next = last_slave ? FPS_ST_OVH : FPS_ST_REQ;
                    end
                end
            end
            FPS_ST_OVH:
            begin
                // Refresh and host time close the round
                ovh_cnt_next = ovh_cnt_reg + 32'h1;
                if (ovh_cnt_next >= ovh_tgt_reg)
                    st_next = FPS_ST_HOLD;
            end
            FPS_ST_HOLD:
            begin
                // Next cycle needs both round and interval done
                if (!poll_enable)
                    st_next = FPS_ST_IDLE;
                else if (msi_cnt_reg >= msi_tgt_reg)
                    st_next = FPS_ST_XFER;
            end
            default:
                st_next = FPS_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= FPS_ST_IDLE;
            spd_reg <= FPS_SPD_9K6;
            slv_reg <= 8'h00;
            nslv_reg <= 8'h00;
            bit_reg <= 4'h0;
            chr_reg <= 9'h000;
            tck_reg <= 16'h0000;
            msi_cnt_reg <= 32'h0;
            msi_tgt_reg <= 32'h0;
            ovh_cnt_reg <= 32'h0;
            ovh_tgt_reg <= 32'h0;
            per_reg <= 32'h0;
            period_reg <= 32'h0;
            cyc_reg <= 1'b0;
            txv_reg <= 1'b0;
            txb_reg <= 8'h00;
            to_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            spd_reg <= spd_next;
            slv_reg <= slv_next;
            nslv_reg <= nslv_next;
            bit_reg <= bit_next;
            chr_reg <= chr_next;
            tck_reg <= tck_next;
            msi_cnt_reg <= msi_cnt_next;
            msi_tgt_reg <= msi_tgt_next;
            ovh_cnt_reg <= ovh_cnt_next;
            ovh_tgt_reg <= ovh_tgt_next;
            per_reg <= per_next;
            period_reg <= period_next;
            cyc_reg <= cyc_next;
            txv_reg <= txv_next;
            txb_reg <= txb_next;
            to_reg <= to_next;
        end
    end

    // Shared and internal buffers, slave table
    always_comb
    begin
        cfg_next = cfg_reg;
        sh_out_next = sh_out_reg;
        sh_in_next = sh_in_reg;
        io_out_next = io_out_reg;
        io_in_next = io_in_reg;
        rx_ptr_next = rx_ptr_reg;
        if (st_reg == FPS_ST_XFER)
        begin
            io_out_next = sh_out_reg;
            sh_in_next = io_in_reg;
        end
        // Host write reaches shared copy only
        if (host_we)
            sh_out_next[host_addr[AW-1:0]] = host_wdata;
        if (drain_valid && drain_ready)
        begin
            if (rx_ptr_reg < cur.in_bytes)
                io_in_next[in_idx[AW-1:0]] = drain_data;
            if (rx_ptr_reg != 8'hFF)
                rx_ptr_next = rx_ptr_reg + 8'h01;
        end
        if (st_reg == FPS_ST_REQ)
            rx_ptr_next = 8'h00;
        if (cfg_we && st_reg == FPS_ST_IDLE)
            cfg_next[cfg_idx[SW-1:0]] = cfg_data;
        rdata_next = sh_in_reg[host_addr[AW-1:0]];
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NSLV; i++)
                cfg_reg[i] <= '0;
            for (int i = 0; i < BUF_DEPTH; i++)
            begin
                sh_out_reg[i] <= 8'h00;
                sh_in_reg[i] <= 8'h00;
                io_out_reg[i] <= 8'h00;
                io_in_reg[i] <= 8'h00;
            end
            rx_ptr_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end
        else
        begin
            cfg_reg <= cfg_next;
            sh_out_reg <= sh_out_next;
            sh_in_reg <= sh_in_next;
            io_out_reg <= io_out_next;
            io_in_reg <= io_in_next;
            rx_ptr_reg <= rx_ptr_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flops
    assign host_rdata = rdata_reg;
    assign poll_state = st_reg;
    assign poll_slave = slv_reg;
    assign tx_byte_valid = txv_reg;
    assign tx_byte = txb_reg;
    assign cycle_start = cyc_reg;
    assign bus_cycle_period = period_reg;
    assign slave_timeout = to_reg;

endmodule // fps_poll_sched

/* tb/fps_poll_sched_chk.sv */
// Assertion checker for the poll scheduler
`timescale 1ns/100ps

module fps_poll_sched_chk
    import fps_pkg::*;
#(
    parameter int NSLV = 8
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic poll_enable,
    input wire fps_state_t poll_state,
    input wire logic [7:0] poll_slave,
    input wire logic tx_byte_valid,
    input wire logic cycle_start,
    input wire logic [NSLV-1:0] slave_timeout
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Legal exits of each poll step
    a_req_to_wait: assert property (poll_state == FPS_ST_REQ ##1
        poll_state != FPS_ST_REQ |-> poll_state == FPS_ST_WAIT)
        else $error("request exit");
    a_wait_exit: assert property (poll_state == FPS_ST_WAIT ##1
        poll_state != FPS_ST_WAIT |-> poll_state inside
        {FPS_ST_RESP, FPS_ST_TSDI}) else $error("wait exit");
    a_resp_to_tsdi: assert property (poll_state == FPS_ST_RESP ##1
        poll_state != FPS_ST_RESP |-> poll_state == FPS_ST_TSDI)
        else $error("response exit");
    a_tsdi_exit: assert property (poll_state == FPS_ST_TSDI ##1
        poll_state != FPS_ST_TSDI |-> poll_state inside
        {FPS_ST_REQ, FPS_ST_OVH}) else $error("turnaround exit");
    // Start, idle, bytes, timeouts
    a_xfer_start: assert property (poll_state == FPS_ST_XFER
        |=> cycle_start) else $error("no cycle start");
    a_idle_hold: assert property (poll_state == FPS_ST_IDLE
        && !poll_enable |=> poll_state == FPS_ST_IDLE) else $error("left idle");
    a_tx_in_req: assert property (tx_byte_valid
        |-> $past(poll_state) == FPS_ST_REQ) else $error("byte outside request");
    a_timeout_flag: assert property (poll_state == FPS_ST_WAIT ##1
        poll_state == FPS_ST_TSDI |-> ##[0:1] slave_timeout[poll_slave])
        else $error("timeout not flagged");
endmodule // fps_poll_sched_chk

bind fps_poll_sched fps_poll_sched_chk #(.NSLV(NSLV)) i_chk (.*);

/* tb/fps_poll_sched_tb.sv */
// Self-checking bench for the poll scheduler
`timescale 1ns/100ps

module fps_poll_sched_tb
    import fps_pkg::*;
;
    localparam int RB = 20, HA = 10, MU = 10, MIN_POLL_INTERVAL = 1500;
    logic core_clk, rstn, poll_enable, cfg_we, host_we, rx_start, rx_valid;
    logic rx_ready, tx_byte_valid, cycle_start;
    logic [15:0] min_poll_interval;
    logic [7:0] slave_count, cfg_idx, host_addr, host_wdata, host_rdata;
    logic [7:0] poll_slave, slave_timeout, mute;
    logic [3:0] host_access_count;
    logic [31:0] bus_cycle_period;
    fps_speed_t speed;
    fps_slave_cfg_t cfg_data;
    fps_byte_t rx_data, tx_byte;
    fps_state_t poll_state;
    int fails, checks, len;

    fps_poll_sched #(.REFRESH_BASE_CYC(RB), .HOST_ACCESS_CYC(HA),
        .MSI_UNIT_CYC(MU)) i_fps_poll_sched (.*);

    fps_slave_model i_fps_slave_model (.*);

    // Free-running core clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chk_near(input string nm, input int e, g, tol);
        checks++;
        if (g < e - tol || g > e + tol)
        begin
            fails++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    // Bounded wait: state, byte or cycle start
    task automatic wait_for(input int k, input fps_state_t s);
        int n;
        n = 0;
        while (!(k == 0 ? poll_state === s : k == 1 ? tx_byte_valid === 1'b1
            : cycle_start === 1'b1))
        begin
            step();
            n++;
            if (n > 60000)
            begin
                fails++;
                wrap_up();
            end
        end
    endtask

    // Cycles spent in the next visit of a state
    task automatic st_len(input fps_state_t s);
        wait_for(0, s);
        len = 0;
        while (poll_state === s && len < 60000)
        begin
            step();
            len++;
        end
        if (len >= 60000)
            fails++;
    endtask

    task automatic put(input bit c, input logic [7:0] a, d, input int t);
        @(posedge core_clk);
        if (c)
            {cfg_we, cfg_idx, cfg_data} <= {1'b1, a, d, 8'h02, 8'h00,
                8'h08, 16'(t)};
        else
            {host_we, host_addr, host_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        {cfg_we, host_we} <= 2'h0;
    endtask

    task automatic t_reset();
        step();
        chk("state", FPS_ST_IDLE, poll_state);
        chk("rx_ready", 1'b1, rx_ready);
        chk("cycle_start", 1'b0, cycle_start);
        $display("reset test done");
    endtask

    // Long interval at 6M with one slave
    task automatic t_msi();
        put(1'b1, 8'h00, 8'h02, 150);
        put(1'b1, 8'h01, 8'h00, 150);
        put(1'b0, 8'h00, 8'h5A, 0);
        put(1'b0, 8'h01, 8'h3C, 0);
        @(posedge core_clk);
        {speed, min_poll_interval} <= {FPS_SPD_6M, 16'(MIN_POLL_INTERVAL)};
        {slave_count, host_access_count, poll_enable} <= {8'h01, 4'h1, 1'b1};
        st_len(FPS_ST_REQ);
        chk_near("request", 121 * 100 / 6, len, 20);
        st_len(FPS_ST_TSDI);
        chk_near("turnaround", 450 * 100 / 6, len, 20);
        st_len(FPS_ST_OVH);
        chk_near("overhead", RB + 120 + HA, len, 1);
        wait_for(2, FPS_ST_IDLE);
        chk("period", 1'b1, bus_cycle_period - MIN_POLL_INTERVAL * MU <= 5);
        @(posedge core_clk) {host_addr, poll_enable} <= {8'h09, 1'b0};
        step();
        step();
        chk("host_rdata", 8'hC1, host_rdata);
        wait_for(0, FPS_ST_IDLE);
        $display("interval test done");
    endtask

    // 12M, mid-cycle host write, silent slave
    task automatic t_round();
        @(posedge core_clk);
        {speed, min_poll_interval, mute} <= {FPS_SPD_12M, 16'h0001, 8'h02};
        {slave_count, host_access_count, poll_enable} <= {8'h02, 4'h0, 1'b1};
        wait_for(2, FPS_ST_IDLE);
        put(1'b0, 8'h00, 8'h77, 0);
        wait_for(1, FPS_ST_IDLE);
        chk("tx byte 0", 8'h5A, tx_byte);
        step();
        wait_for(1, FPS_ST_IDLE);
        chk("tx byte 1", 8'h3C, tx_byte);
        st_len(FPS_ST_TSDI);
        chk_near("turnaround", 800 * 100 / 12, len, 12);
        st_len(FPS_ST_WAIT);
        chk_near("reply wait", 150 * 100 / 12, len, 12);
        wait_for(2, FPS_ST_IDLE);
        chk("timeout", 8'h02, slave_timeout);
        @(posedge core_clk) mute <= 8'h00;
        wait_for(1, FPS_ST_IDLE);
        chk("tx new", 8'h77, tx_byte);
        st_len(FPS_ST_RESP);
        chk_near("response", 121 * 100 / 12, len, 12);
        st_len(FPS_ST_RESP);
        step();
        chk("timeout clear", 8'h00, slave_timeout);
        $display("round test done");
    endtask

    // Main sequence
    initial
    begin
        {rstn, poll_enable, cfg_we, host_we} = 4'h0;
        {speed, min_poll_interval, slave_count} = {FPS_SPD_12M, 24'h0};
        {host_access_count, cfg_idx, cfg_data} = 60'h0;
        {host_addr, host_wdata, mute} = 24'h0;
        {fails, checks} = 64'h0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_msi();
        t_round();
        wrap_up();
    end
endmodule // fps_poll_sched_tb

/* tb/fps_slave_model.sv */
// Slave station model answering polls
`timescale 1ns/100ps

module fps_slave_model
    import fps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire fps_state_t poll_state,
    input wire logic [7:0] poll_slave,
    input wire logic [7:0] mute,
    input wire logic rx_ready,
    output logic rx_start,
    output logic rx_valid,
    output fps_byte_t rx_data
);
    int wcnt;
    int sent;

    // Answer after wait opens, then two bytes
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {rx_start, rx_valid} <= 2'h0;
            rx_data <= 8'h00;
            wcnt <= 0;
            sent <= 0;
        end
        else
        begin
            wcnt <= (poll_state == FPS_ST_WAIT) ? wcnt + 1 : 0;
            rx_start <= poll_state == FPS_ST_WAIT && wcnt >= 4
                && !mute[poll_slave[2:0]];
            if (poll_state == FPS_ST_REQ)
                sent <= 0;
            if (rx_valid && rx_ready)
            begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data; // Differs from last byte
                sent <= sent + 1;
            end
            else if (!rx_valid && poll_state == FPS_ST_RESP && sent < 2)
            begin
                rx_valid <= 1'b1;
                rx_data <= {4'hC, poll_slave[1:0], sent[1:0]};
            end
        end
    end
endmodule // fps_slave_model
